// [hdl/uartc_pkg.sv]
/*
 * uartc_pkg: register indices, field layouts, reset values and timing
 * constants of the serial control-three / data-port block.
 * Assumes a 32-bit classic Wishbone bus with byte address = 4 * index.
 */
package uartc_pkg;

    localparam int DW     = 8;
    localparam int IDX_W  = 3;
    localparam int BAUD_W = 16;
    localparam int FLAG_W = 7;
    localparam int EV_W   = 3;

    // register indices
    localparam logic [IDX_W-1:0] IDX_CTRL  = 3'h0;
    localparam logic [IDX_W-1:0] IDX_BAUD  = 3'h1;
    localparam logic [IDX_W-1:0] IDX_FLAG  = 3'h2;
    localparam logic [IDX_W-1:0] IDX_ISTAT = 3'h3;
    localparam logic [IDX_W-1:0] IDX_IMASK = 3'h4;
    localparam logic [IDX_W-1:0] IDX_C3    = 3'h6;
    localparam logic [IDX_W-1:0] IDX_DATA  = 3'h7;

    // error positions, same order as the enables of control three
    localparam int ERR_OVR   = 3;
    localparam int ERR_NOISE = 2;
    localparam int ERR_FRAME = 1;
    localparam int ERR_PAR   = 0;

    // oversampling and frame timing, in ticks and bits
    localparam logic [3:0] OVS_LAST   = 4'hf;
    localparam logic [3:0] SMP_FIRST  = 4'h7;
    localparam logic [3:0] SMP_LAST   = 4'h9;
    localparam logic [3:0] FRAME_BASE = 4'ha;
    localparam logic [3:0] DLAST_8    = 4'h7;
    localparam logic [3:0] DLAST_9    = 4'h8;

    typedef struct packed {
        logic par_odd;
        logic par_en;
        logic two_stop;
        logic receiver_source_sel;
        logic internal_loop_select;
        logic nine_bit;
        logic rx_en;
        logic tx_en;
    } uartc_ctrl_s;

    typedef struct packed {
        logic       tx_ninth_bit;
        logic       single_wire_pin_direction;
        logic       transmit_polarity_invert;
        logic [3:0] err_en;
    } uartc_c3_s;

    typedef struct packed {
        logic [3:0] err;
        logic       tx_done;
        logic       tx_empty;
        logic       rx_full;
    } uartc_flag_s;

    typedef struct packed {
        logic [8:0] data;
        logic       noise;
        logic       ferr;
    } uartc_rx_s;

    localparam uartc_ctrl_s CTRL_RST = 8'h00;
    localparam uartc_c3_s   C3_RST   = 7'h00;
    localparam uartc_flag_s FLAG_RST = 7'h06;
    localparam logic [EV_W-1:0] EV_RST = 3'h0;
    localparam logic [DW-1:0]   DATA_RST = 8'h00;

endpackage

// [hdl/uartc_rx.sv]
/*
 * uartc_rx: receive shifter with 16x oversampling and 3-sample vote.
 * Assumes line_i already synchronised and tick_i from a divider.
 */
`timescale 1ns/1ps
module uartc_rx
    import uartc_pkg::*;
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic srst_i,
    // control
    input  wire logic en_i,
    input  wire logic tick_i,
    input  wire logic nine_i,
    input  wire logic line_i,
    // result
    output logic      done_o,
    output uartc_rx_s res_o
);
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} uartc_rxst_e;

    uartc_rxst_e st_r, st_nxt;
    logic [3:0]  tk_r, tk_nxt;
    logic [3:0]  bc_r, bc_nxt;
    logic [2:0]  smp_r, smp_nxt;
    logic [8:0]  sh_r, sh_nxt;
    logic        nz_r, nz_nxt;
    logic        done_r, done_nxt;
    uartc_rx_s   res_r, res_nxt;
    logic        bit_v, noisy, last;

    always_comb begin
        st_nxt   = st_r;
        tk_nxt   = tk_r;
        bc_nxt   = bc_r;
        smp_nxt  = smp_r;
        sh_nxt   = sh_r;
        nz_nxt   = nz_r;
        res_nxt  = res_r;
        done_nxt = 1'b0;
        bit_v    = (smp_r[0] & smp_r[1]) | (smp_r[0] & smp_r[2]) | (smp_r[1] & smp_r[2]);
        noisy    = (|smp_r) & ~(&smp_r);
        last     = (tk_r == OVS_LAST);
        if (!en_i) begin
            st_nxt = RX_IDLE;
        end else if (tick_i) begin
            tk_nxt = tk_r + 4'h1;
            if (tk_r >= SMP_FIRST && tk_r <= SMP_LAST) begin
                smp_nxt = {smp_r[1:0], line_i};
            end
            if (last) begin
                nz_nxt = nz_r | noisy;
            end
            unique case (st_r)
                RX_IDLE: if (!line_i) begin
                    st_nxt = RX_START;
                    tk_nxt = 4'h1;
                    nz_nxt = 1'b0;
                end
                RX_START: if (last) begin
                    st_nxt = bit_v ? RX_IDLE : RX_DATA;
                    bc_nxt = 4'h0;
                end
                RX_DATA: if (last) begin
                    sh_nxt = {bit_v, sh_r[8:1]};
                    bc_nxt = bc_r + 4'h1;
                    if (bc_r == (nine_i ? DLAST_9 : DLAST_8)) begin
                        st_nxt = RX_STOP;
                    end
                end
                RX_STOP: if (last) begin
                    st_nxt        = RX_IDLE;
                    done_nxt      = 1'b1;
                    res_nxt.data  = nine_i ? sh_r : {1'b0, sh_r[8:1]};
                    res_nxt.noise = nz_r | noisy;
                    res_nxt.ferr  = !bit_v;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_r   <= RX_IDLE;
            tk_r   <= 4'h0;
            bc_r   <= 4'h0;
            smp_r  <= 3'h7;
            sh_r   <= '0;
            nz_r   <= 1'b0;
            done_r <= 1'b0;
            res_r  <= '0;
        end else begin
            st_r   <= st_nxt;
            tk_r   <= tk_nxt;
            bc_r   <= bc_nxt;
            smp_r  <= smp_nxt;
            sh_r   <= sh_nxt;
            nz_r   <= nz_nxt;
            done_r <= done_nxt;
            res_r  <= res_nxt;
        end
    end

    assign done_o = done_r;
    assign res_o  = res_r;
endmodule

// [hdl/uartc_top.sv]
/*
 * uartc_top: control-three register, data port, flags, interrupts,
 * baud divider and transmit pin handling of an asynchronous serial unit.
 * Assumes a classic Wishbone master, 32-bit data, a single clock.
 */
`timescale 1ns/1ps
module uartc_top
    import uartc_pkg::*;
#(
    parameter logic [BAUD_W-1:0] BAUD_RST = 16'h0001,
    parameter int                ADR_W    = 8
) (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              srst_i,
    // wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADR_W-1:0]  wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // serial pins
    input  wire logic              rxd_i,
    input  wire logic              txd_i,
    output logic                   txd_o,
    output logic                   txd_oe_o,
    // interrupts
    output logic                   irq_o,
    output logic                   err_irq_o
);

    // bus side
    logic              ack_r, ack_nxt;
    logic [31:0]       rdat_r, rdat_nxt;
    logic              hit;
    logic              acc;
    logic              wr;
    logic              rd;
    logic [IDX_W-1:0]  idx;

    // software registers
    uartc_ctrl_s       ctrl_r, ctrl_nxt;
    uartc_c3_s         c3_r, c3_nxt;
    logic [BAUD_W-1:0] baud_r, baud_nxt;
    logic [EV_W-1:0]   mask_r, mask_nxt;
    logic [EV_W-1:0]   ev_r, ev_nxt;
    logic [EV_W-1:0]   ev_set;

    // data path state
    uartc_flag_s       flg_r, flg_nxt;
    logic [DW-1:0]     tdr_r, tdr_nxt;
    logic [DW-1:0]     rdr_r, rdr_nxt;
    logic              rx9_r, rx9_nxt;
    logic              arm_r, arm_nxt;
    logic              par_bad;

    // divider, pins, shifters
    logic [BAUD_W-1:0] cnt_r, cnt_nxt;
    logic              tick;
    logic              rxd_s1_r, rxd_s2_r;
    logic              txp_s1_r, txp_s2_r;
    logic              txd_r, txd_nxt;
    logic              oe_r, oe_nxt;
    logic              single;
    logic              rx_line;
    logic              tx_line;
    logic              tx_busy;
    logic              tx_go;
    logic              rx_done;
    uartc_rx_s         rx_res;

    // true when the bus access in flight addresses register b
    function automatic logic at(input logic             go,
                                input logic [IDX_W-1:0] a,
                                input logic [IDX_W-1:0] b);
        return go && (a == b);
    endfunction

    // byte-lane merge for a write
    function automatic logic [DW-1:0] lane(input logic [DW-1:0] old,
                                           input logic [DW-1:0] val,
                                           input logic          en);
        return en ? val : old;
    endfunction

    assign hit = wb_cyc_i && wb_stb_i;
    assign acc = hit && ack_r;
    assign wr  = acc && wb_we_i;
    assign rd  = acc && !wb_we_i;
    assign idx = wb_adr_i[IDX_W+1:2];

    //--- bus answer
    always_comb begin
        ack_nxt  = hit && !ack_r;
        rdat_nxt = rdat_r;
        if (hit && !ack_r) begin
            rdat_nxt = '0;
            case (idx)
                IDX_CTRL:  rdat_nxt[DW-1:0]     = ctrl_r;
                IDX_BAUD:  rdat_nxt[BAUD_W-1:0] = baud_r;
                IDX_FLAG:  rdat_nxt[FLAG_W-1:0] = flg_r;
                IDX_ISTAT: rdat_nxt[EV_W-1:0]   = ev_r;
                IDX_IMASK: rdat_nxt[EV_W-1:0]   = mask_r;
                IDX_C3:    rdat_nxt[DW-1:0]     = {rx9_r, c3_r};
                IDX_DATA:  rdat_nxt[DW-1:0]     = rdr_r;
                default:   rdat_nxt             = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ack_r  <= 1'b0;
            rdat_r <= '0;
        end else begin
            ack_r  <= ack_nxt;
            rdat_r <= rdat_nxt;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;

    //--- configuration registers
    always_comb begin
        ctrl_nxt = ctrl_r;
        c3_nxt   = c3_r;
        baud_nxt = baud_r;
        mask_nxt = mask_r;
        if (at(wr, idx, IDX_CTRL)) begin
            ctrl_nxt = lane(ctrl_r, wb_dat_i[7:0], wb_sel_i[0]);
        end
        if (at(wr, idx, IDX_C3) && wb_sel_i[0]) begin
            // ninth transmit bit changes only here
            c3_nxt = wb_dat_i[6:0];
        end
        if (at(wr, idx, IDX_BAUD)) begin
            baud_nxt[7:0]  = lane(baud_r[7:0], wb_dat_i[7:0], wb_sel_i[0]);
            baud_nxt[15:8] = lane(baud_r[15:8], wb_dat_i[15:8], wb_sel_i[1]);
        end
        if (at(wr, idx, IDX_IMASK) && wb_sel_i[0]) begin
            mask_nxt = wb_dat_i[EV_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ctrl_r <= CTRL_RST;
            c3_r   <= C3_RST;
            baud_r <= BAUD_RST;
            mask_r <= EV_RST;
        end else begin
            ctrl_r <= ctrl_nxt;
            c3_r   <= c3_nxt;
            baud_r <= baud_nxt;
            mask_r <= mask_nxt;
        end
    end

    //--- baud divider, 16 ticks per bit
    always_comb begin
        tick    = (baud_r != '0) && (cnt_r >= baud_r - 16'h0001);
        cnt_nxt = tick ? '0 : cnt_r + 16'h0001;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    //--- pin synchronisers
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rxd_s1_r <= 1'b1;
            rxd_s2_r <= 1'b1;
            txp_s1_r <= 1'b1;
            txp_s2_r <= 1'b1;
        end else begin
            rxd_s1_r <= rxd_i;
            rxd_s2_r <= rxd_s1_r;
            txp_s1_r <= txd_i;
            txp_s2_r <= txp_s1_r;
        end
    end

    // receiver source: pin, internal loop, or shared transmit pin
    assign single  = ctrl_r.internal_loop_select && ctrl_r.receiver_source_sel;
    assign rx_line = !ctrl_r.internal_loop_select ? rxd_s2_r :
                     (ctrl_r.receiver_source_sel ? txp_s2_r : tx_line);

    //--- transmit pin
    always_comb begin
        txd_nxt = tx_line ^ c3_r.transmit_polarity_invert;
        oe_nxt  = single ? c3_r.single_wire_pin_direction : 1'b1;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            txd_r <= 1'b1;
            oe_r  <= 1'b1;
        end else begin
            txd_r <= txd_nxt;
            oe_r  <= oe_nxt;
        end
    end

    assign txd_o    = txd_r;
    assign txd_oe_o = oe_r;

    //--- shifters
    assign tx_go = ctrl_r.tx_en && !flg_r.tx_empty && !tx_busy;

    uartc_tx u_tx (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .tick_i (tick),
        .load_i (tx_go),
        .data_i ({c3_r.tx_ninth_bit, tdr_r}),
        .nine_i (ctrl_r.nine_bit),
        .two_i  (ctrl_r.two_stop),
        .busy_o (tx_busy),
        .line_o (tx_line)
    );

    uartc_rx u_rx (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .en_i   (ctrl_r.rx_en),
        .tick_i (tick),
        .nine_i (ctrl_r.nine_bit),
        .line_i (rx_line),
        .done_o (rx_done),
        .res_o  (rx_res)
    );

    // even parity over nine bits unless odd is chosen
    assign par_bad = ctrl_r.par_en && ctrl_r.nine_bit && ((^rx_res.data) ^ ctrl_r.par_odd);

    //--- data port and flags
    always_comb begin
        flg_nxt = flg_r;
        tdr_nxt = tdr_r;
        rdr_nxt = rdr_r;
        rx9_nxt = rx9_r;
        arm_nxt = arm_r;
        // status read arms the clear, data read completes it
        if (at(rd, idx, IDX_DATA) && arm_r) begin
            flg_nxt.rx_full = 1'b0;
            flg_nxt.err     = 4'h0;
            arm_nxt         = 1'b0;
        end
        if (at(rd, idx, IDX_FLAG)) begin
            arm_nxt = 1'b1;
        end
        if (at(wr, idx, IDX_DATA) && wb_sel_i[0]) begin
            tdr_nxt          = wb_dat_i[7:0];
            flg_nxt.tx_empty = 1'b0;
        end
        if (tx_go) begin
            flg_nxt.tx_empty = 1'b1;
        end
        flg_nxt.tx_done = flg_nxt.tx_empty && !tx_busy && !tx_go;
        // hardware sets after the clears so a same-cycle event survives
        if (rx_done) begin
            if (flg_nxt.rx_full) begin
                flg_nxt.err[ERR_OVR] = 1'b1;
            end else begin
                // byte and ninth bit replaced together
                rdr_nxt                = rx_res.data[7:0];
                rx9_nxt                = rx_res.data[8];
                flg_nxt.rx_full        = 1'b1;
                flg_nxt.err[ERR_NOISE] = flg_nxt.err[ERR_NOISE] | rx_res.noise;
                flg_nxt.err[ERR_FRAME] = flg_nxt.err[ERR_FRAME] | rx_res.ferr;
                flg_nxt.err[ERR_PAR]   = flg_nxt.err[ERR_PAR] | par_bad;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            flg_r <= FLAG_RST;
            tdr_r <= DATA_RST;
            rdr_r <= DATA_RST;
            rx9_r <= 1'b0;
            arm_r <= 1'b0;
        end else begin
            flg_r <= flg_nxt;
            tdr_r <= tdr_nxt;
            rdr_r <= rdr_nxt;
            rx9_r <= rx9_nxt;
            arm_r <= arm_nxt;
        end
    end

    //--- sticky events, write one to clear, set wins
    always_comb begin
        ev_set    = '0;
        ev_set[0] = rx_done && !flg_r.rx_full;
        ev_set[1] = tx_go;
        ev_set[2] = |(flg_nxt.err & ~flg_r.err);
        ev_nxt    = ev_r;
        if (at(wr, idx, IDX_ISTAT) && wb_sel_i[0]) begin
            ev_nxt = ev_r & ~wb_dat_i[EV_W-1:0];
        end
        ev_nxt = ev_nxt | ev_set;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ev_r <= EV_RST;
        end else begin
            ev_r <= ev_nxt;
        end
    end

    assign irq_o     = |(ev_r & mask_r);
    assign err_irq_o = |(flg_r.err & c3_r.err_en);

endmodule

// [hdl/uartc_tx.sv]
/*
 * uartc_tx: transmit shifter, one frame per load pulse, 16 ticks per bit.
 * Assumes load_i only while busy_o is low and tick_i from a divider.
 */
`timescale 1ns/1ps
module uartc_tx
    import uartc_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    // frame setup
    input  wire logic       tick_i,
    input  wire logic       load_i,
    input  wire logic [8:0] data_i,
    input  wire logic       nine_i,
    input  wire logic       two_i,
    // line
    output logic            busy_o,
    output logic            line_o
);
    typedef enum logic {TX_IDLE, TX_SHIFT} uartc_txst_e;

    uartc_txst_e st_r, st_nxt;
    logic [11:0] sh_r, sh_nxt;
    logic [3:0]  tk_r, tk_nxt;
    logic [3:0]  bc_r, bc_nxt;

    always_comb begin
        st_nxt = st_r;
        sh_nxt = sh_r;
        tk_nxt = tk_r;
        bc_nxt = bc_r;
        unique case (st_r)
            TX_IDLE: if (load_i) begin
                // start low, data lsb first, ones as stop bits
                sh_nxt = {2'b11, nine_i ? data_i[8] : 1'b1, data_i[7:0], 1'b0};
                bc_nxt = FRAME_BASE + {3'h0, nine_i} + {3'h0, two_i};
                tk_nxt = 4'h0;
                st_nxt = TX_SHIFT;
            end
            TX_SHIFT: if (tick_i) begin
                tk_nxt = tk_r + 4'h1;
                if (tk_r == OVS_LAST) begin
                    sh_nxt = {1'b1, sh_r[11:1]};
                    bc_nxt = bc_r - 4'h1;
                    if (bc_r == 4'h1) begin
                        st_nxt = TX_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_r <= TX_IDLE;
            sh_r <= '1;
            tk_r <= 4'h0;
            bc_r <= 4'h0;
        end else begin
            st_r <= st_nxt;
            sh_r <= sh_nxt;
            tk_r <= tk_nxt;
            bc_r <= bc_nxt;
        end
    end

    assign busy_o = (st_r == TX_SHIFT);
    assign line_o = busy_o ? sh_r[0] : 1'b1;
endmodule

// [tb/uartc_peer.sv]
/* uartc_peer: remote serial device that sends and captures frames.
   Assumes 16 clocks per bit (divider of 1) and an idle-high line. */
`timescale 1ns/1ps
module uartc_peer (
    // clock
    input  wire logic clk_i,
    // line from the device, frame size
    input  wire logic line_i,
    input  wire logic nine_i,
    // line to the device, captured frame
    output logic       rxd_o,
    output logic [8:0] got_o,
    output int         cnt_o
);
    int i;

    initial begin
        rxd_o = 1'b1;
        got_o = 9'h000;
        cnt_o = 0;
    end

    // capture; mid-start recheck rejects short glitches
    always begin
        @(posedge clk_i iff !line_i);
        repeat (8) @(posedge clk_i);
        if (!line_i) begin
            got_o = 9'h000;
            for (i = 0; i < (nine_i ? 9 : 8); i++) begin
                repeat (16) @(posedge clk_i);
                got_o[i] = line_i;
            end
            repeat (16) @(posedge clk_i);
            cnt_o++;
        end
    end

    // one frame, lsb first, stop level chosen by caller
    task automatic send(input logic [8:0] v, input logic nine, input logic stop);
        int k;
        @(posedge clk_i);
        rxd_o <= 1'b0;
        for (k = 0; k < (nine ? 9 : 8); k++) begin
            repeat (16) @(posedge clk_i);
            rxd_o <= v[k];
        end
        repeat (16) @(posedge clk_i);
        rxd_o <= stop;
        repeat (16) @(posedge clk_i);
        rxd_o <= 1'b1;
        repeat (16) @(posedge clk_i);
    endtask
endmodule

// [tb/uartc_top_asserts.sv]
/* uartc_top_asserts: bus, pin and interrupt relations at the uartc_top ports.
   Assumes it is bound to uartc_top, one clock, synchronous reset. */
`timescale 1ns/1ps
module uartc_top_asserts
    import uartc_pkg::*;
#(
    parameter int ADR_W = 8
) (
    // clock and reset
    input wire logic             clk_i,
    input wire logic             srst_i,
    // wishbone
    input wire logic             wb_cyc_i,
    input wire logic             wb_stb_i,
    input wire logic             wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0]       wb_sel_i,
    input wire logic [31:0]      wb_dat_i,
    input wire logic [31:0]      wb_dat_o,
    input wire logic             wb_ack_o,
    // pins and interrupts
    input wire logic             rxd_i,
    input wire logic             txd_i,
    input wire logic             txd_o,
    input wire logic             txd_oe_o,
    input wire logic             irq_o,
    input wire logic             err_irq_o
);
    logic [IDX_W-1:0] idx;
    logic             wr;
    logic             rd;
    logic [6:0]       c3_r;
    logic [6:0]       c3_nxt;

    assign idx = wb_adr_i[4:2];
    assign wr  = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
    assign rd  = wb_cyc_i & wb_stb_i & ~wb_we_i & wb_ack_o;

    // shadow of the writable control-three bits
    always_comb begin
        c3_nxt = c3_r;
        if (wr && idx == IDX_C3) begin
            c3_nxt = wb_dat_i[6:0];
        end
    end
    always_ff @(posedge clk_i) begin
        c3_r <= srst_i ? 7'h00 : c3_nxt;
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);

    a_ack_timely: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_rd_upper_zero: assert property (rd |-> wb_dat_o[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    a_unmapped_zero: assert property (rd && idx == 3'h5 |-> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_c3_readback: assert property (rd && idx == IDX_C3 |-> wb_dat_o[6:0] == c3_r)
        else $error("control three lost a written bit");
    a_err_gate_off: assert property (c3_r[3:0] == 4'h0 |-> !err_irq_o)
        else $error("error request with all enables clear");
    a_irq_mask_off: assert property (wr && idx == IDX_IMASK && wb_dat_i[2:0] == 3'h0 |=> !irq_o)
        else $error("interrupt with mask clear");
    a_oe_drive: assert property (wr && idx == IDX_C3 && wb_dat_i[5] |-> ##2 txd_oe_o)
        else $error("pin not driven with direction bit set");
    a_idle_high: assert property ($fell(srst_i) |-> txd_o && txd_oe_o && !irq_o && !err_irq_o)
        else $error("pins not idle after reset");

    c_rx_read: cover property (rd && idx == IDX_DATA);
    c_err_irq: cover property ($rose(err_irq_o));
    c_single_wire: cover property ($fell(txd_oe_o));
endmodule

// [tb/uartc_top_test.sv]
/* uartc_top_test: register-level bench for uartc_top with a serial peer.
   Assumes a 40 MHz clock and a baud divider of 1, 16 clocks per bit. */
`timescale 1ns/1ps
module uartc_top_test
    import uartc_pkg::*;
;
    logic        clk_i  = 1'b0;
    logic        srst_i = 1'b1;
    logic        cyc    = 1'b0;
    logic        stb    = 1'b0;
    logic        we     = 1'b0;
    logic [7:0]  adr    = 8'h00;
    logic [3:0]  sel    = 4'h0;
    logic [31:0] dat    = 32'h0000_0000;
    logic        nine   = 1'b0;
    logic        inv    = 1'b0;
    logic [31:0] dat_o;
    logic [31:0] q;
    logic [8:0]  got;
    logic        ack;
    logic        txd_o;
    logic        txd_oe_o;
    logic        txd_i;
    logic        irq_o;
    logic        err_irq_o;
    logic        line;
    logic        rxd;
    int          cnt;
    int          i;
    int          mismatches = 0;
    int          checked    = 0;

    always #12.5 clk_i = ~clk_i;
    // pull-up while the device releases the pin
    assign txd_i = txd_oe_o ? txd_o : 1'b1;
    assign line  = txd_i ^ inv;

    uartc_top #(.BAUD_RST(16'h0001), .ADR_W(8)) dut (
        .clk_i(clk_i), .srst_i(srst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .rxd_i(rxd), .txd_i(txd_i),
        .txd_o(txd_o), .txd_oe_o(txd_oe_o), .irq_o(irq_o), .err_irq_o(err_irq_o));
    uartc_peer u_peer (.clk_i(clk_i), .line_i(line), .nine_i(nine), .rxd_o(rxd),
        .got_o(got), .cnt_o(cnt));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic chkb(input logic seen, input logic exp);
        chk({31'h0, seen}, {31'h0, exp});
    endtask

    task automatic close_out;
        if (mismatches == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // one classic cycle, read data left in q
    task automatic wb(input logic w, input logic [2:0] idx, input logic [31:0] d);
        int k;
        k = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= {3'b000, idx, 2'b00};
        sel <= 4'h3;
        dat <= d;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1 && k < 20);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (k >= 20) begin
            mismatches++;
            close_out();
        end
        @(posedge clk_i);
    endtask

    task automatic txw(input logic [7:0] v, input logic [8:0] exp);
        int c;
        int k;
        c = cnt;
        wb(1'b1, IDX_DATA, {24'h00_0000, v});
        for (k = 0; k < 600 && cnt == c; k++) begin
            @(posedge clk_i);
        end
        if (cnt == c) begin
            mismatches++;
            close_out();
        end
        chk({23'h00_0000, got}, {23'h00_0000, exp});
    endtask

    initial begin
        repeat (4) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        chkb(txd_o, 1'b1);
        wb(1'b0, IDX_C3, 32'h0); chk(q, 32'h0000_0000);
        wb(1'b0, IDX_FLAG, 32'h0); chk(q, 32'h0000_0006);
        wb(1'b0, IDX_BAUD, 32'h0); chk(q, 32'h0000_0001);
        wb(1'b1, 3'h5, 32'h0000_00ff);
        wb(1'b0, 3'h5, 32'h0); chk(q, 32'h0000_0000);
        // plain frame, then empty receive buffer read and transmit event
        wb(1'b1, IDX_CTRL, 32'h0000_0003);
        txw(8'ha5, 9'h0a5);
        wb(1'b0, IDX_DATA, 32'h0); chk(q, 32'h0000_0000);
        wb(1'b1, IDX_IMASK, 32'h0000_0002); chkb(irq_o, 1'b1);
        wb(1'b1, IDX_ISTAT, 32'h0000_0002); chkb(irq_o, 1'b0);
        // nine-bit frames, ninth bit kept
        nine <= 1'b1;
        wb(1'b1, IDX_CTRL, 32'h0000_0007);
        wb(1'b1, IDX_C3, 32'h0000_0040);
        txw(8'h3c, 9'h13c);
        txw(8'h55, 9'h155);
        // receive with ninth bit
        u_peer.send(9'h15a, 1'b1, 1'b1);
        wb(1'b0, IDX_C3, 32'h0); chk(q & 32'h80, 32'h0000_0080);
        wb(1'b0, IDX_FLAG, 32'h0); chk(q & 32'h1, 32'h0000_0001);
        wb(1'b0, IDX_DATA, 32'h0); chk(q, 32'h0000_005a);
        wb(1'b0, IDX_FLAG, 32'h0); chk(q & 32'h1, 32'h0000_0000);
        wb(1'b1, IDX_IMASK, 32'h0000_0001); chkb(irq_o, 1'b1);
        wb(1'b1, IDX_ISTAT, 32'h0000_0001); chkb(irq_o, 1'b0);
        wb(1'b1, IDX_IMASK, 32'h0);
        // parity and framing faults, then overrun
        wb(1'b1, IDX_CTRL, 32'h0000_0047);
        wb(1'b1, IDX_C3, 32'h0);
        u_peer.send(9'h001, 1'b1, 1'b0);
        u_peer.send(9'h001, 1'b1, 1'b0);
        chkb(err_irq_o, 1'b0);
        for (i = 0; i < 4; i++) begin
            wb(1'b1, IDX_C3, 32'h1 << i);
            chkb(err_irq_o, 1'(4'hb >> i));
        end
        wb(1'b1, IDX_C3, 32'h0000_000f); chkb(err_irq_o, 1'b1);
        wb(1'b0, IDX_FLAG, 32'h0); chk(q & 32'h78, 32'h0000_0058);
        wb(1'b0, IDX_DATA, 32'h0); chkb(err_irq_o, 1'b0);
        // inverted line, two stop bits
        nine <= 1'b0;
        wb(1'b1, IDX_CTRL, 32'h0000_0023);
        wb(1'b1, IDX_C3, 32'h0000_0010);
        inv <= 1'b1;
        repeat (2) @(posedge clk_i);
        chkb(txd_o, 1'b0);
        txw(8'h96, 9'h096);
        wb(1'b1, IDX_C3, 32'h0);
        inv <= 1'b0;
        // single-wire pin direction
        wb(1'b1, IDX_CTRL, 32'h0000_001b);
        repeat (2) @(posedge clk_i);
        chkb(txd_oe_o, 1'b0);
        wb(1'b1, IDX_C3, 32'h0000_0020);
        repeat (2) @(posedge clk_i);
        chkb(txd_oe_o, 1'b1);
        wb(1'b1, IDX_C3, 32'h0);
        wb(1'b1, IDX_CTRL, 32'h0000_0003);
        repeat (2) @(posedge clk_i);
        chkb(txd_oe_o, 1'b1);
        close_out();
    end
endmodule

bind uartc_top uartc_top_asserts #(.ADR_W(ADR_W)) u_chk (
    .clk_i(clk_i), .srst_i(srst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rxd_i(rxd_i), .txd_i(txd_i),
    .txd_o(txd_o), .txd_oe_o(txd_oe_o), .irq_o(irq_o), .err_irq_o(err_irq_o));
